/* hw/mcd_cfg.svh */
`ifndef MCD_CFG_SVH
`define MCD_CFG_SVH

// Avalon byte offsets and the address bit that selects the register window
`define MCD_OFS_INSTR 6'h00
`define MCD_OFS_STATUS 6'h04
`define MCD_OFS_REG_BASE 6'h20
`define MCD_REG_SEL_HI 5
`define MCD_REG_SEL_LO 5

// Status register bit positions
`define MCD_STAT_BUSY 0
`define MCD_STAT_ERR 1

// Instruction field positions (bit 15 is the first opcode bit)
`define MCD_OP_HI 15
`define MCD_OP_LO 13
`define MCD_S_HI 12
`define MCD_S_LO 8
`define MCD_RL_HI 7
`define MCD_RL_LO 5
`define MCD_D_HI 4
`define MCD_D_LO 0

// Operand codes
`define MCD_OP_MOVE 3'h0
`define MCD_D_INVALID 5'h08
`define MCD_ADDR_LOW 3'h7

// Reset values and the full-byte mask
`define MCD_WAITREQ_RST 1'b1
`define MCD_OE_N_RST 1'b1
`define MCD_FULL_MASK 8'hFF

`endif

/* hw/mcd_pkg.sv */
package mcd_pkg;

    // Quarter of the instruction cycle
    typedef enum logic [1:0] {
        MCD_Q0 = 2'b00,
        MCD_Q1 = 2'b01,
        MCD_Q2 = 2'b10,
        MCD_Q3 = 2'b11
    } mcd_quarter_e;

    // Move form, {source on bus, destination on bus}
    typedef enum logic [1:0] {
        MCD_F_RR = 2'b00,
        MCD_F_RI = 2'b01,
        MCD_F_IR = 2'b10,
        MCD_F_II = 2'b11
    } mcd_form_e;

    typedef struct packed {
        logic [7:0][7:0] regs;
        logic [15:0] instr;
        mcd_quarter_e quarter;
        logic busy;
        logic err;
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] latch;
        logic [7:0] result;
        logic address_strobe;
        logic write_strobe;
        logic bank_select;
        logic [7:0] pb_out;
        logic pb_oe_n;
        logic waitreq;
        logic [31:0] rdata;
    } mcd_state_s;

    // Right rotate within the byte, amount always 0..7
    function automatic logic [7:0] mcd_rotr(input logic [7:0] d, input logic [2:0] n);
        logic [15:0] w;
        w = {d, d} >> n;
        return w[7:0];
    endfunction

    // Length field to low-bit mask, zero meaning all eight bits
    function automatic logic [7:0] mcd_lmask(input logic [2:0] len);
        logic [8:0] w;
        w = (9'h001 << len) - 9'h001;
        return (len == 3'h0) ? 8'hFF : w[7:0];
    endfunction

endpackage

/* hw/mcd_rotmerge.sv */
`timescale 1ns/1ps
// Rotate, length mask, shift and merge with the I/O latch contents
module mcd_rotmerge
    import mcd_pkg::*;
(
    // Data in
    input wire logic [7:0] src,
    input wire logic [7:0] latch,
    // Controls
    input wire logic [2:0] rot,
    input wire logic [2:0] shift,
    input wire logic [2:0] len,
    input wire logic mask_en,
    input wire logic merge_en,
    input wire logic full,
    // Result
    output logic [7:0] res
);
    logic [7:0] rotated;
    logic [7:0] mask;
    logic [7:0] placed;

    // Rotation and positioning
    always_comb begin
        rotated = mcd_rotr(src, rot);
        placed = 8'(rotated << shift);
        mask = full ? 8'hFF : 8'(mcd_lmask(len) << shift);
        if (merge_en) begin
            res = (placed & mask) | (latch & ~mask);
        end else if (mask_en) begin
            res = rotated & mcd_lmask(len);
        end else begin
            res = rotated;
        end
    end
endmodule

/* hw/mcd_top.sv */
`timescale 1ns/1ps
`include "mcd_cfg.svh"
module mcd_top
    import mcd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Peripheral bus pins
    input wire logic [7:0] peripheral_bus_in,
    output logic [7:0] peripheral_bus_out,
    output logic peripheral_bus_oe_n,
    output logic address_strobe,
    output logic write_strobe,
    output logic bank_select
);
    mcd_state_s s_reg;
    mcd_state_s s_next;
    logic [4:0] src_code;
    logic [4:0] dst_code;
    logic [2:0] rl_field;
    mcd_form_e form;
    logic addr_dst;
    logic opp_bank;
    logic [7:0] src_val;
    logic [7:0] latch_eff;
    logic [7:0] merged;
    logic req;
    logic hit_cmd;

    // Field decode of the instruction in flight
    assign src_code = s_reg.instr[`MCD_S_HI:`MCD_S_LO];
    assign dst_code = s_reg.instr[`MCD_D_HI:`MCD_D_LO];
    assign rl_field = s_reg.instr[`MCD_RL_HI:`MCD_RL_LO];
    assign form = mcd_form_e'({src_code[4], dst_code[4]});
    assign addr_dst = !dst_code[4] && (dst_code[2:0] == `MCD_ADDR_LOW);
    assign opp_bank = (form == MCD_F_II) && (src_code[3] != dst_code[3]);
    assign req = read | write;
    assign hit_cmd = (address == `MCD_OFS_INSTR) || address[`MCD_REG_SEL_HI];

    // Data entering the datapath; the latch value is final at the end of quarter Q1
    assign latch_eff = (s_reg.quarter == MCD_Q1) ? s_reg.sync2 : s_reg.latch;
    assign src_val = src_code[4] ? latch_eff : s_reg.regs[src_code[2:0]];

    // Rotate amount, shift and mask per form
    mcd_rotmerge u_rotmerge (
        .src(src_val),
        .latch(latch_eff),
        .rot((form == MCD_F_RR) ? rl_field : ((form == MCD_F_RI) ? 3'h0 : src_code[2:0])),
        .shift(dst_code[4] ? dst_code[2:0] : 3'h0),
        .len(rl_field),
        .mask_en(form == MCD_F_IR),
        .merge_en(dst_code[4]),
        .full(opp_bank),
        .res(merged)
    );

    // Next state
    always_comb begin
        logic in_ph;
        logic out_ph;
        logic n_src_io;
        logic n_dst_io;
        logic n_addr;
        logic [4:0] n_s;
        logic [4:0] n_d;
        in_ph = 1'b0;
        out_ph = 1'b0;
        n_src_io = 1'b0;
        n_dst_io = 1'b0;
        n_addr = 1'b0;
        n_s = 5'h00;
        n_d = 5'h00;
        s_next = s_reg;

        // Pin synchroniser
        s_next.sync1 = peripheral_bus_in;
        s_next.sync2 = s_reg.sync1;

        // Quarter sequencing of one instruction
        if (s_reg.busy) begin
            unique case (s_reg.quarter)
                MCD_Q0: begin
                    s_next.latch = s_reg.sync2;
                    s_next.quarter = MCD_Q1;
                end
                MCD_Q1: begin
                    s_next.latch = s_reg.sync2;
                    s_next.result = merged;
                    s_next.quarter = MCD_Q2;
                end
                MCD_Q2: begin
                    s_next.quarter = MCD_Q3;
                end
                MCD_Q3: begin
                    s_next.quarter = MCD_Q0;
                    s_next.busy = 1'b0;
                    if (!dst_code[4] && !addr_dst) begin
                        if (dst_code == `MCD_D_INVALID) begin
                            s_next.err = 1'b1;
                        end else begin
                            s_next.regs[dst_code[2:0]] = s_reg.result;
                        end
                    end
                end
            endcase
        end

        // Avalon slave, one wait cycle, commands stall while busy
        if (!req) begin
            s_next.waitreq = 1'b1;
        end else if (s_reg.waitreq) begin
            if (!(write && hit_cmd && s_reg.busy)) begin
                s_next.waitreq = 1'b0;
                s_next.rdata = 32'h0000_0000;
                if (address == `MCD_OFS_INSTR) begin
                    s_next.rdata[15:0] = s_reg.instr;
                end else if (address == `MCD_OFS_STATUS) begin
                    s_next.rdata[`MCD_STAT_BUSY] = s_reg.busy;
                    s_next.rdata[`MCD_STAT_ERR] = s_reg.err;
                end else if (address[`MCD_REG_SEL_HI] && address[1:0] == 2'h0) begin
                    s_next.rdata[7:0] = s_reg.regs[address[4:2]];
                end
            end
        end else begin
            s_next.waitreq = 1'b1;
            if (write && address == `MCD_OFS_INSTR && byteenable[1:0] == 2'h3) begin
                s_next.instr = writedata[15:0];
                s_next.busy = (writedata[`MCD_OP_HI:`MCD_OP_LO] == `MCD_OP_MOVE);
                s_next.quarter = MCD_Q0;
            end else if (write && address == `MCD_OFS_STATUS && byteenable[0]) begin
                s_next.err = s_next.err & ~writedata[`MCD_STAT_ERR];
                if (s_reg.busy && s_reg.quarter == MCD_Q3 && dst_code == `MCD_D_INVALID) begin
                    s_next.err = 1'b1;
                end
            end else if (write && address[`MCD_REG_SEL_HI] && byteenable[0]) begin
                s_next.regs[address[4:2]] = writedata[7:0];
            end
        end

        // Pin states derived from the next quarter
        n_s = s_next.instr[`MCD_S_HI:`MCD_S_LO];
        n_d = s_next.instr[`MCD_D_HI:`MCD_D_LO];
        n_src_io = n_s[4];
        n_dst_io = n_d[4];
        n_addr = !n_dst_io && (n_d[2:0] == `MCD_ADDR_LOW);
        in_ph = s_next.busy && (s_next.quarter == MCD_Q0 || s_next.quarter == MCD_Q1);
        out_ph = s_next.busy && (s_next.quarter == MCD_Q2 || s_next.quarter == MCD_Q3);
        s_next.address_strobe = out_ph && n_addr;
        s_next.write_strobe = out_ph && n_dst_io;
        if (in_ph) begin
            s_next.bank_select = n_dst_io ? n_d[3] : (n_src_io & n_s[3]);
        end else if (out_ph) begin
            s_next.bank_select = (n_dst_io || n_addr) & n_d[3];
        end else begin
            s_next.bank_select = 1'b0;
        end
        if (out_ph && (n_dst_io || n_addr)) begin
            s_next.pb_oe_n = 1'b0;
            s_next.pb_out = s_next.result;
        end else begin
            s_next.pb_oe_n = 1'b1;
            s_next.pb_out = 8'h00;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.waitreq <= `MCD_WAITREQ_RST;
            s_reg.pb_oe_n <= `MCD_OE_N_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign readdata = s_reg.rdata;
    assign waitrequest = s_reg.waitreq;
    assign peripheral_bus_out = s_reg.pb_out;
    assign peripheral_bus_oe_n = s_reg.pb_oe_n;
    assign address_strobe = s_reg.address_strobe;
    assign write_strobe = s_reg.write_strobe;
    assign bank_select = s_reg.bank_select;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_drive_quarters: assert property (
        !peripheral_bus_oe_n |-> s_reg.busy && s_reg.quarter[1])
        else $error("bus driven outside output phase");
    chk_strobe_input: assert property (
        s_reg.busy && !s_reg.quarter[1] |-> !address_strobe && !write_strobe)
        else $error("strobe high in input phase");
    chk_write_strobe: assert property (
        s_reg.busy && s_reg.quarter[1] && dst_code[4] |-> write_strobe && !address_strobe)
        else $error("bus destination strobes wrong");
    chk_bank_addr: assert property (
        s_reg.busy && s_reg.quarter[1] && addr_dst |-> bank_select == dst_code[3])
        else $error("bank select wrong for address output");
    chk_bank_input: assert property (
        s_reg.busy && !s_reg.quarter[1] && form == MCD_F_IR |-> bank_select == src_code[3])
        else $error("input bank select does not follow source");
    chk_rotate_rr: assert property (
        s_reg.busy && s_reg.quarter == MCD_Q1 && form == MCD_F_RR
        |=> s_reg.result == mcd_rotr($past(src_val), rl_field))
        else $error("register move not rotated");
    chk_len_zero: assert property (
        s_reg.busy && s_reg.quarter == MCD_Q1 && form == MCD_F_IR
        |=> (s_reg.result & ~mcd_lmask(rl_field)) == 8'h00)
        else $error("upper bits not zero");
    chk_full_write: assert property (
        s_reg.busy && s_reg.quarter == MCD_Q1 && opp_bank
        |-> ##1 s_reg.result == 8'(mcd_rotr($past(latch_eff), src_code[2:0]) << dst_code[2:0]))
        else $error("opposite bank write not full");
    chk_drive_len: assert property (
        s_reg.busy && s_reg.quarter == MCD_Q1 && dst_code[4] |=> !peripheral_bus_oe_n [*2])
        else $error("bus not driven for both output quarters");
endmodule

/* verification/mcd_periph.sv */
`timescale 1ns/1ps
// Peripheral on the far side of the bus pins
module mcd_periph (
    // Pin side of the block
    input wire logic clk,
    input wire logic [7:0] peripheral_bus_out,
    input wire logic peripheral_bus_oe_n,
    input wire logic write_strobe,
    // Byte the selected device offers
    input wire logic [7:0] dev_data,
    // Wire level and last byte taken
    output logic [7:0] peripheral_bus_in,
    output logic [7:0] captured
);
    // Wire level, block wins only while its drivers are on
    assign peripheral_bus_in = peripheral_bus_oe_n ? dev_data : peripheral_bus_out;
    // Device takes the byte while the write strobe is high
    always_ff @(posedge clk) begin
        if (write_strobe && !peripheral_bus_oe_n) begin
            captured <= peripheral_bus_out;
        end
    end
endmodule

/* verification/mcd_top_tb.sv */
`timescale 1ns/1ps
module mcd_top_tb;
    logic clk, rst_n, read, write, waitrequest, oe_n, a_s, w_s, b_s;
    logic [5:0] address;
    logic [3:0] byteenable, in_ph, out_ph;
    logic [31:0] writedata, readdata, rd;
    logic [7:0] pb_in, pb_out, dev_data, captured, a_out;
    int errors, num_checks;

    mcd_top u_dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .peripheral_bus_in(pb_in), .peripheral_bus_out(pb_out),
        .peripheral_bus_oe_n(oe_n), .address_strobe(a_s), .write_strobe(w_s),
        .bank_select(b_s));
    mcd_periph u_periph (.clk(clk), .peripheral_bus_out(pb_out), .peripheral_bus_oe_n(oe_n),
        .write_strobe(w_s), .dev_data(dev_data), .peripheral_bus_in(pb_in),
        .captured(captured));

    // Clock generation
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Verdict and end of run
    task automatic tally_and_finish();
        if (errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Compare one value
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One Avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        n = 0;
        // Waitrequest and read data are taken at the rising edge only
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (waitrequest !== 1'b0) begin
            errors++;
            tally_and_finish();
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    // Start a move and sample pins in both phases
    task automatic run(input logic [4:0] s, input logic [2:0] r, input logic [4:0] d);
        bus(1'b1, 6'h00, {16'h0000, 3'h0, s, r, d});
        #1;
        in_ph = {oe_n, a_s, w_s, b_s};
        repeat (2) @(posedge clk);
        #1;
        out_ph = {oe_n, a_s, w_s, b_s};
        a_out = pb_out;
        repeat (3) @(posedge clk);
    endtask

    // Reference right rotate
    function automatic logic [7:0] rr(input logic [7:0] v, input logic [2:0] n);
        logic [15:0] w;
        w = {v, v} >> n;
        return w[7:0];
    endfunction

    // Main sequence
    initial begin
        rst_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 6'h00;
        byteenable = 4'hF;
        writedata = 32'h0;
        dev_data = 8'h9C;
        errors = 0;
        num_checks = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("waitrequest in reset", 8'h01, {7'h0, waitrequest});
        chk("oe_n in reset", 8'h01, {7'h0, oe_n});
        bus(1'b1, 6'h24, 32'h0000_00B4);
        bus(1'b0, 6'h24, 32'h0);
        chk("reg1", 8'hB4, rd[7:0]);
        bus(1'b0, 6'h10, 32'h0);
        chk("unmapped", 8'h00, rd[7:0]);
        run(5'h01, 3'h3, 5'h02);
        chk("rr in pins", 8'h08, {4'h0, in_ph});
        chk("rr out pins", 8'h08, {4'h0, out_ph});
        bus(1'b0, 6'h28, 32'h0);
        chk("reg2", rr(8'hB4, 3'h3), rd[7:0]);
        run(5'h01, 3'h7, 5'h07);
        chk("dest07 out pins", 8'h04, {4'h0, out_ph});
        chk("dest07 data", rr(8'hB4, 3'h7), a_out);
        run(5'h01, 3'h0, 5'h0F);
        chk("dest17 out pins", 8'h05, {4'h0, out_ph});
        run(5'h15, 3'h4, 5'h03);
        chk("low bank in pins", 8'h08, {4'h0, in_ph});
        bus(1'b0, 6'h2C, 32'h0);
        chk("reg3", rr(8'h9C, 3'h5) & 8'h0F, rd[7:0]);
        run(5'h1C, 3'h0, 5'h04);
        chk("high bank in pins", 8'h09, {4'h0, in_ph});
        bus(1'b0, 6'h30, 32'h0);
        chk("reg4", rr(8'h9C, 3'h4), rd[7:0]);
        run(5'h15, 3'h0, 5'h08);
        bus(1'b0, 6'h04, 32'h0);
        chk("error set", 8'h02, rd[7:0] & 8'h02);
        bus(1'b0, 6'h20, 32'h0);
        chk("reg0 untouched", 8'h00, rd[7:0]);
        bus(1'b1, 6'h04, 32'h0000_0002);
        bus(1'b0, 6'h04, 32'h0);
        chk("error cleared", 8'h00, rd[7:0] & 8'h02);
        run(5'h01, 3'h3, 5'h13);
        chk("rb in pins", 8'h08, {4'h0, in_ph});
        chk("rb out pins", 8'h02, {4'h0, out_ph});
        chk("rb data", (8'h9C & ~8'h38) | ((8'hB4 & 8'h07) << 3), captured);
        run(5'h11, 3'h3, 5'h18);
        chk("bb far in pins", 8'h09, {4'h0, in_ph});
        chk("bb far out pins", 8'h03, {4'h0, out_ph});
        chk("bb far data", rr(8'h9C, 3'h1), captured);
        run(5'h12, 3'h2, 5'h11);
        chk("bb near data", (8'h9C & ~8'h06) | ((rr(8'h9C, 3'h2) & 8'h03) << 1), a_out);
        chk("bb near taken", (8'h9C & ~8'h06) | ((rr(8'h9C, 3'h2) & 8'h03) << 1), captured);
        tally_and_finish();
    end
endmodule
